// File: hw/nci_pkg.sv
package nci_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ      = 100;
  localparam int COLL_MIN_MS  = 1;
  localparam int COLL_MAX_MS  = 2;
  localparam int COLL_MIN_CYC = COLL_MIN_MS * CLK_MHZ * 1000;
  localparam int COLL_MAX_CYC = COLL_MAX_MS * CLK_MHZ * 1000;
  localparam int COLL_CNT_W   = 18;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_VEC  = 8'h0C;
  localparam logic [7:0] ADDR_PEND = 8'h10;

  // ==========================================================
  // Field positions
  localparam int CTRL_CMD_IE  = 0;
  localparam int CTRL_RCV_IE  = 1;
  localparam int CTRL_PRI_LSB = 4;
  localparam int CTRL_GO      = 8;
  localparam int STAT_W       = 4;

  // ==========================================================
  // Reset values and constants
  localparam logic [2:0]  BOARD_PRI_RST = 3'h5;
  localparam logic [3:0]  MASK_RST      = 4'h0;
  localparam logic [7:0]  VEC_BASE_RST  = 8'hC0;
  localparam logic [7:0]  CMD_VEC_OFS   = 8'h04;
  localparam logic [15:0] MIN_FRAME_LEN = 16'h0040;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic rcv;
    logic cmd;
  } nci_ev_t;

  typedef struct packed {
    logic coll_fail;
    logic coll_ok;
    logic rcv;
    logic cmd;
  } nci_flags_t;

  typedef struct packed {
    logic       req;
    logic [7:0] vec;
  } nci_vec_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } nci_coll_st_t;

endpackage

// File: hw/nci_irq_logic.sv
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// Contract
// - Enabled command completion flags done, requests command vector
// - Receive without receive enable: flag only
// - Enabled receive completion flags done, requests receive vector
// - Command without command enable: flag only
// - Both enabled: loopback yields both interrupts
// - No interrupt while its done flag clear
// - Deliver only when processor priority below board; only vreq is gated, irq ignores processor priority
// - Correct vector, only with its enable set
// - Collision test sends minimum self frame, checks
module nci_irq_logic #(
  parameter int COLL_MIN = nci_pkg::COLL_MIN_CYC,
  parameter int COLL_MAX = nci_pkg::COLL_MAX_CYC
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Datapath completion events
  input  wire nci_pkg::nci_ev_t     ev,
  input  wire logic                 tx_end,
  output logic                      tx_start,
  output logic      [15:0]          tx_len,
  output logic                      tx_to_self,
  // Pins from host bus and transceiver
  input  wire logic [2:0]           proc_pri,
  input  wire logic                 int_ack,
  input  wire logic                 col_det,
  // Interrupt outputs
  output nci_pkg::nci_vec_t         vreq,
  output logic                      irq
);
  import nci_pkg::*;

  logic [31:0]               ctrl_reg;
  nci_flags_t                stat_reg;
  logic [3:0]                mask_reg;
  logic [7:0]                vec_base_reg;
  logic                      pend_cmd_reg;
  logic                      pend_rcv_reg;
  logic                      sel_rcv_reg;
  logic                      wr_pend_reg;
  logic [7:0]                wr_addr_reg;
  logic [2:0]                pri_s1, pri_s2;
  logic                      ack_s1, ack_s2, ack_d;
  logic                      col_s1, col_s2;
  nci_coll_st_t              st_reg;
  logic [COLL_CNT_W-1:0]     cnt_reg;
  nci_flags_t                set_ev;
  logic                      ack_edge;
  logic                      go;
  logic                      wr_stat;
  logic [2:0]                board_pri;
  logic                      rcv_ok;
  logic                      cmd_ok;

  function automatic logic [7:0] vec_of(input logic rcv, input logic [7:0] base);
    vec_of = rcv ? base : 8'(base + CMD_VEC_OFS);
  endfunction

  assign board_pri = ctrl_reg[CTRL_PRI_LSB +: 3];
  assign ack_edge  = ack_s2 && !ack_d;
  assign wr_stat   = wr_pend_reg && (wr_addr_reg == ADDR_STAT);
  assign rcv_ok    = pend_rcv_reg && stat_reg.rcv && ctrl_reg[CTRL_RCV_IE];
  assign cmd_ok    = pend_cmd_reg && stat_reg.cmd && ctrl_reg[CTRL_CMD_IE];
  assign go        = wr_pend_reg && (wr_addr_reg == ADDR_CTRL) && hwdata[CTRL_GO]
                     && (st_reg == ST_IDLE);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pri_s1 <= 3'h7;
      pri_s2 <= 3'h7;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_d  <= 1'b0;
      col_s1 <= 1'b0;
      col_s2 <= 1'b0;
    end
    else
    begin
      pri_s1 <= proc_pri;
      pri_s2 <= pri_s1;
      ack_s1 <= int_ack;
      ack_s2 <= ack_s1;
      ack_d  <= ack_s2;
      col_s1 <= col_det;
      col_s2 <= col_s1;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end
    else
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
      wr_addr_reg <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
      begin
        case (haddr[7:0])
          ADDR_CTRL: hrdata <= ctrl_reg;
          ADDR_STAT: hrdata <= {28'h0000000, stat_reg};
          ADDR_MASK: hrdata <= {28'h0000000, mask_reg};
          ADDR_VEC:  hrdata <= {24'h000000, vec_base_reg};
          ADDR_PEND: hrdata <= {28'h0000000, st_reg, pend_rcv_reg, pend_cmd_reg};
          default:   hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Control, mask and vector registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg     <= {25'h0000000, BOARD_PRI_RST, 4'h0};
      mask_reg     <= MASK_RST;
      vec_base_reg <= VEC_BASE_RST;
    end
    else if (wr_pend_reg)
    begin
      case (wr_addr_reg)
        ADDR_CTRL: ctrl_reg <= {25'h0000000, hwdata[CTRL_PRI_LSB +: 3], 2'h0,
                                hwdata[CTRL_RCV_IE], hwdata[CTRL_CMD_IE]};
        ADDR_MASK: mask_reg <= hwdata[3:0];
        ADDR_VEC:  vec_base_reg <= hwdata[7:0];
        default:   ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // ==========================================================
  // Sticky status, write one to clear, set wins
  always_comb
  begin
    set_ev           = '0;
    set_ev.cmd       = ev.cmd || (st_reg == ST_DONE);
    set_ev.rcv       = ev.rcv;
    set_ev.coll_ok   = (st_reg == ST_WAIT) && col_s2 && (cnt_reg >= COLL_CNT_W'(COLL_MIN));
    set_ev.coll_fail = (st_reg == ST_WAIT) && ((col_s2 && (cnt_reg < COLL_CNT_W'(COLL_MIN)))
                       || (!col_s2 && (cnt_reg >= COLL_CNT_W'(COLL_MAX))));
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stat_reg <= '0;
    else
      stat_reg <= (stat_reg & ~(wr_stat ? hwdata[3:0] : 4'h0)) | set_ev;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(stat_reg & mask_reg);
  end

  // ==========================================================
  // Vectored requests
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend_cmd_reg <= 1'b0;
      pend_rcv_reg <= 1'b0;
    end
    else
    begin
      if (set_ev.cmd && ctrl_reg[CTRL_CMD_IE])
        pend_cmd_reg <= 1'b1;
      else if (!stat_reg.cmd || (ack_edge && vreq.req && !sel_rcv_reg))
        pend_cmd_reg <= 1'b0;
      if (set_ev.rcv && ctrl_reg[CTRL_RCV_IE])
        pend_rcv_reg <= 1'b1;
      else if (!stat_reg.rcv || (ack_edge && vreq.req && sel_rcv_reg))
        pend_rcv_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vreq        <= '0;
      sel_rcv_reg <= 1'b0;
    end
    else
    begin
      if (!vreq.req)
        sel_rcv_reg <= rcv_ok;
      vreq.vec <= vec_of(vreq.req ? sel_rcv_reg : rcv_ok, vec_base_reg);
      // Held request drops when its own source withdraws, then re-arbitrates
      vreq.req <= !ack_s2 && (pri_s2 < board_pri)
                  && (vreq.req ? (sel_rcv_reg ? rcv_ok : cmd_ok) : (rcv_ok || cmd_ok))
                  && !(ack_edge && vreq.req);
    end
  end

  // ==========================================================
  // Collision-detect self test
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg     <= ST_IDLE;
      cnt_reg    <= '0;
      tx_start   <= 1'b0;
      tx_len     <= 16'h0000;
      tx_to_self <= 1'b0;
    end
    else
    begin
      tx_start <= 1'b0;
      case (st_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            st_reg     <= ST_SEND;
            tx_start   <= 1'b1;
            tx_len     <= MIN_FRAME_LEN;
            tx_to_self <= 1'b1;
          end
        end
        ST_SEND:
        begin
          cnt_reg <= '0;
          if (tx_end)
            st_reg <= ST_WAIT;
        end
        ST_WAIT:
        begin
          cnt_reg <= cnt_reg + 1'b1;
          if (set_ev.coll_ok || set_ev.coll_fail)
            st_reg <= ST_DONE;
        end
        ST_DONE:
        begin
          tx_to_self <= 1'b0;
          st_reg     <= ST_IDLE;
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_cmd_done_req: assert property (ev.cmd && ctrl_reg[CTRL_CMD_IE]
    |=> stat_reg.cmd && pend_cmd_reg) else $error("command done not pending");
  a_rcv_silent: assert property (ev.rcv && !ctrl_reg[CTRL_RCV_IE] && !pend_rcv_reg
    |=> stat_reg.rcv && !pend_rcv_reg) else $error("receive pended while off");
  a_rcv_done_req: assert property (ev.rcv && ctrl_reg[CTRL_RCV_IE]
    |=> stat_reg.rcv && pend_rcv_reg) else $error("receive done not pending");
  a_cmd_silent: assert property (ev.cmd && !ctrl_reg[CTRL_CMD_IE] && !pend_cmd_reg
    && st_reg != ST_DONE |=> stat_reg.cmd && !pend_cmd_reg)
    else $error("command pended while off");
  a_both_pend: assert property (ev.cmd && ev.rcv && ctrl_reg[1:0] == 2'h3
    |=> pend_cmd_reg && pend_rcv_reg) else $error("both not pending");
  a_req_has_done: assert property (vreq.req
    |-> (sel_rcv_reg ? $past(stat_reg.rcv) : $past(stat_reg.cmd)))
    else $error("request without done");
  a_pri_gate: assert property (vreq.req |-> $past(pri_s2) < $past(board_pri))
    else $error("request at blocked priority");
  a_vec_value: assert property (vreq.req
    |-> vreq.vec == vec_of(sel_rcv_reg, $past(vec_base_reg))) else $error("wrong vector");
  a_req_enabled: assert property (vreq.req
    |-> (sel_rcv_reg ? $past(ctrl_reg[CTRL_RCV_IE]) : $past(ctrl_reg[CTRL_CMD_IE])))
    else $error("request without enable");
  a_self_frame: assert property (tx_start |-> tx_to_self && tx_len == MIN_FRAME_LEN
    && st_reg == ST_SEND) else $error("bad self test frame");
  a_coll_window: assert property (set_ev.coll_ok |-> cnt_reg >= COLL_CNT_W'(COLL_MIN)
    ##1 st_reg == ST_DONE ##1 stat_reg.cmd) else $error("collision window wrong");
  a_ack_clear: assert property (ack_edge && vreq.req && sel_rcv_reg && !set_ev.rcv
    |=> !pend_rcv_reg && !vreq.req) else $error("ack did not clear");

  c_cmd_int:  cover property (vreq.req && !sel_rcv_reg ##[1:20] ack_edge);
  c_rcv_int:  cover property (vreq.req && sel_rcv_reg ##[1:20] ack_edge);
  c_pri_hold: cover property (pend_cmd_reg && !vreq.req ##1 pend_cmd_reg && vreq.req);
  c_coll_ok:  cover property (set_ev.coll_ok);

endmodule

// File: tb/nci_host_model.sv
`timescale 1ns/1ns
module nci_host_model (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Vectored interrupt bus
  input  wire nci_pkg::nci_vec_t vreq,
  input  wire logic signed [31:0] ack_dly,
  output logic                   int_ack,
  output logic [7:0]             last_vec,
  output int                     ack_cnt,
  // Transceiver
  input  wire logic              tx_end,
  input  wire logic signed [31:0] coll_dly,
  output logic                   col_det
);
  import nci_pkg::*;
  int   wait_cnt;
  int   col_cnt;
  logic col_arm;

  // ======
  // Grant after ack_dly cycles, hold until request drops
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      int_ack  <= 1'b0;
      wait_cnt <= 0;
      ack_cnt  <= 0;
      last_vec <= 8'h00;
    end
    else if (int_ack)
      int_ack <= vreq.req;
    else if (!vreq.req)
      wait_cnt <= 0;
    else if (wait_cnt >= ack_dly)
    begin
      int_ack  <= 1'b1;
      last_vec <= vreq.vec;
      ack_cnt  <= ack_cnt + 1;
      wait_cnt <= 0;
    end
    else
      wait_cnt <= wait_cnt + 1;

  // ======
  // Collision answer coll_dly cycles after frame end, negative for none
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      col_arm <= 1'b0;
      col_cnt <= 0;
      col_det <= 1'b0;
    end
    else if (tx_end)
    begin
      col_arm <= 1'b1;
      col_cnt <= 0;
    end
    else if (col_arm)
    begin
      col_cnt <= col_cnt + 1;
      col_det <= (coll_dly >= 0) && (col_cnt >= coll_dly) && (col_cnt < coll_dly + 8);
      col_arm <= (col_cnt < 100);
    end
endmodule

// File: tb/nci_irq_logic_bench.sv
`timescale 1ns/1ns
module nci_irq_logic_bench;
  import nci_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        tx_end;
  logic [1:0]  htrans;
  logic [2:0]  cpu_pri;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        tx_start;
  logic [15:0] tx_len;
  logic        tx_to_self;
  logic        int_ack;
  logic        col_det;
  logic        irq;
  logic [7:0]  last_vec;
  nci_vec_t    vreq;
  nci_ev_t     ev;
  int          ack_cnt;
  int          bad_count;
  int          tests_run;
  int          cyc;
  int          coll_dly;
  int          ack_dly;
  int          acks;
  logic [7:0]  cv = VEC_BASE_RST + CMD_VEC_OFS;
  logic [31:0] ctl [5] = '{32'h51, 32'h51, 32'h52, 32'h52, 32'h53};
  nci_ev_t     evs [5] = '{2'b01, 2'b10, 2'b10, 2'b01, 2'b11};
  logic [31:0] stv [5] = '{32'h1, 32'h2, 32'h2, 32'h1, 32'h3};
  logic [31:0] nak [5] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h2};
  logic [2:0]  hi [2]  = '{3'h5, 3'h7};
  logic [2:0]  lo [2]  = '{3'h4, 3'h0};
  int          dly [3] = '{30, 2, -1};
  logic [31:0] cst [3] = '{32'h5, 32'h9, 32'h9};

  nci_irq_logic #(.COLL_MIN(20), .COLL_MAX(40)) uut (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ev(ev),
    .tx_end(tx_end), .tx_start(tx_start), .tx_len(tx_len), .tx_to_self(tx_to_self),
    .proc_pri(cpu_pri), .int_ack(int_ack), .col_det(col_det), .vreq(vreq), .irq(irq));

  nci_host_model host (
    .mclk(mclk), .rst_n(rst_n), .vreq(vreq), .ack_dly(ack_dly), .int_ack(int_ack),
    .last_vec(last_vec), .ack_cnt(ack_cnt), .tx_end(tx_end), .coll_dly(coll_dly),
    .col_det(col_det));

  // ======
  // Clock, timeout, tasks
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test;
    end
  end

  task end_of_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (hresp !== 1'b0)
      chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task pulse(input nci_ev_t v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 2'b00;
  endtask

  // ======
  // Scenarios
  initial
  begin
    {rst_n, hsel, hwrite, tx_end, htrans, haddr, hwdata, ev} = '0;
    {cpu_pri, cyc, bad_count, tests_run, ack_dly} = '0;
    coll_dly = -1;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rchk("ctrl", ADDR_CTRL, 32'h50);
    rchk("vector base", ADDR_VEC, {24'h0, VEC_BASE_RST});
    rchk("mask", ADDR_MASK, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      ack_dly = (i == 4) ? 6 : 0;
      acks = ack_cnt;
      ahb(1'b1, ADDR_STAT, 32'hF);
      ahb(1'b1, ADDR_CTRL, ctl[i]);
      pulse(evs[i]);
      repeat (40) @(posedge mclk);
      rchk("status", ADDR_STAT, stv[i]);
      chk("grants", nak[i], 32'(ack_cnt - acks));
      chk("vector", (i == 2 || i == 3) ? VEC_BASE_RST : cv, last_vec);
      rchk("pending", ADDR_PEND, 32'h0);
    end
    ahb(1'b1, ADDR_CTRL, 32'h51);
    for (int j = 0; j < 2; j++)
    begin
      cpu_pri <= hi[j];
      ahb(1'b1, ADDR_STAT, 32'hF);
      acks = ack_cnt;
      pulse(2'b01);
      repeat (40) @(posedge mclk);
      chk("held", 32'h0, 32'(ack_cnt - acks));
      rchk("pending held", ADDR_PEND, 32'h1);
      cpu_pri <= lo[j];
      repeat (40) @(posedge mclk);
      chk("released", 32'h1, 32'(ack_cnt - acks));
    end
    cpu_pri <= 3'h7;
    acks = ack_cnt;
    pulse(2'b01);
    ahb(1'b1, ADDR_STAT, 32'h1);
    cpu_pri <= 3'h0;
    repeat (40) @(posedge mclk);
    chk("no done no grant", 32'h0, 32'(ack_cnt - acks));
    ahb(1'b1, ADDR_CTRL, 32'h50);
    ahb(1'b1, ADDR_MASK, 32'h1);
    pulse(2'b01);
    repeat (4) @(posedge mclk);
    chk("irq set", 32'h1, {31'h0, irq});
    ahb(1'b1, ADDR_STAT, 32'h1);
    repeat (4) @(posedge mclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    pulse(2'b10);
    repeat (4) @(posedge mclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    for (int k = 0; k < 3; k++)
    begin
      coll_dly = dly[k];
      ahb(1'b1, ADDR_STAT, 32'hF);
      ahb(1'b1, ADDR_CTRL, 32'h150);
      for (int n = 0; n < 20 && tx_start !== 1'b1; n++)
        @(posedge mclk);
      chk("frame start", 32'h1, {31'h0, tx_start});
      chk("frame length", {16'h0, MIN_FRAME_LEN}, {16'h0, tx_len});
      chk("to self", 32'h1, {31'h0, tx_to_self});
      repeat (3) @(posedge mclk);
      tx_end <= 1'b1;
      @(posedge mclk);
      tx_end <= 1'b0;
      repeat (80) @(posedge mclk);
      rchk("collision status", ADDR_STAT, cst[k]);
    end
    end_of_test;
  end
endmodule
